// [rtl/order_params.svh]
// How it works
// [RULE1] id widths: four master, four port, eight target
// [RULE2] single-order source may tie id constant
// [RULE3] write beats of one burst sent consecutively
// [RULE4] write data follows address order, no id
// [RULE5] legacy interleave depth configured to one
// [RULE6] write data tag derived from address id
// [RULE7] same id to one peripheral stays ordered
// [RULE8] same id overlapping memory stays ordered
// [RULE9] ordering id carries the port bits
// [RULE10] same id same direction responses in order
// [RULE11] cross-direction order needs waiting for response
// [RULE12] rely only on responses from final point
// [RULE13] cache bits three to one nonzero means normal
// [RULE14] overlap means sharing one atomic range
// [RULE15] fabric keeps same id order per direction
// [RULE16] fabric keeps write and read response order
// [RULE17] id re-tagging keeps original id ordering
// [RULE18] early responder keeps order until arrival
// [RULE19] responded transactions seen by all later ones
// [RULE20] writes visible to later writes before response
// [RULE21] device reads seen by later same-id reads
// [RULE22] same id responses returned in arrival order
`ifndef ORDER_PARAMS_SVH
`define ORDER_PARAMS_SVH
`define MST_ID_W 4
`define PORT_ID_W 4
`define SLV_ID_W 8
`define ADDR_W 16
`define DATA_W 32
`define LEN_W 8
`define CACHE_W 4
`define CACHE_KIND_HI 3
`define CACHE_KIND_LO 1
`define CACHE_KIND_DEVICE 3'h0
`define QUEUE_DEPTH 4
`define MEM_AW 8
`define PORT_NUM 4'h0
`define FIXED_ID 4'h0
`define WR_INTERLEAVE_DEPTH 1
`define OUT_W 4
`endif

// [rtl/order_pkg.sv]
`include "order_params.svh"
package order_pkg;
  typedef enum logic [0:0] {W_IDLE, W_DATA} wr_state_t;
  typedef enum logic [1:0] {M_IDLE, M_AW, M_AR, M_W} src_state_t;
  typedef logic [`SLV_ID_W-1:0] tag_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`LEN_W-1:0] len_t;
endpackage : order_pkg

// [rtl/order_link.sv]
`timescale 1ns/1ns
`include "order_params.svh"
interface order_link;
  // write address
  logic aw_valid;
  logic aw_ready;
  logic [`MST_ID_W-1:0] aw_id;
  logic [`ADDR_W-1:0] aw_addr;
  logic [`LEN_W-1:0] aw_len;
  logic [`CACHE_W-1:0] aw_cache;
  // write data, no id
  logic w_valid;
  logic w_ready;
  logic [`DATA_W-1:0] w_data;
  logic w_last;
  // write response
  logic b_valid;
  logic b_ready;
  logic [`MST_ID_W-1:0] b_id;
  // read address
  logic ar_valid;
  logic ar_ready;
  logic [`MST_ID_W-1:0] ar_id;
  logic [`ADDR_W-1:0] ar_addr;
  logic [`LEN_W-1:0] ar_len;
  logic [`CACHE_W-1:0] ar_cache;
  // read data
  logic r_valid;
  logic r_ready;
  logic [`MST_ID_W-1:0] r_id;
  logic [`DATA_W-1:0] r_data;
  logic r_last;

  modport src (
    output aw_valid, aw_id, aw_addr, aw_len, aw_cache,
    input aw_ready,
    output w_valid, w_data, w_last,
    input w_ready,
    input b_valid, b_id,
    output b_ready,
    output ar_valid, ar_id, ar_addr, ar_len, ar_cache,
    input ar_ready,
    input r_valid, r_id, r_data, r_last,
    output r_ready
  );

  modport tgt (
    input aw_valid, aw_id, aw_addr, aw_len, aw_cache,
    output aw_ready,
    input w_valid, w_data, w_last,
    output w_ready,
    output b_valid, b_id,
    input b_ready,
    input ar_valid, ar_id, ar_addr, ar_len, ar_cache,
    output ar_ready,
    output r_valid, r_id, r_data, r_last,
    input r_ready
  );
endinterface : order_link

// [rtl/order_queue.sv]
`timescale 1ns/1ns
module order_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // fill side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] data_i,
  // drain side
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  // status
  output logic full_o,
  output logic empty_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] slot [0:DEPTH-1];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  wire do_push = push_i && !full_o;
  wire do_pop = pop_i && !empty_o;

  assign empty_o = (wr_ptr == rd_ptr);
  assign full_o = (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]) &&
                  (wr_ptr[PW] != rd_ptr[PW]);
  assign head_o = slot[rd_ptr[PW-1:0]];

  // strict arrival order: oldest entry always leaves first
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce_i) begin
      if (do_push) begin
        slot[wr_ptr[PW-1:0]] <= data_i;
        wr_ptr <= wr_ptr + (PW+1)'(1);
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + (PW+1)'(1);
      end
    end
  end
endmodule : order_queue

// [rtl/order_target.sv]
`timescale 1ns/1ns
`include "order_params.svh"
module order_target
  import order_pkg::*;
#(
  parameter logic [`PORT_ID_W-1:0] PORT_NUM = `PORT_NUM,
  parameter int DEPTH = `QUEUE_DEPTH,
  parameter int MEM_AW = `MEM_AW
) (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // link
  order_link.tgt link,
  // write completion report
  output logic wr_done_o,
  output logic [`SLV_ID_W-1:0] wr_tag_o,
  output logic wr_normal_o,
  // read completion report
  output logic rd_done_o,
  output logic [`SLV_ID_W-1:0] rd_tag_o,
  output logic rd_normal_o
);
  localparam int RQ_W = `SLV_ID_W + `ADDR_W + `LEN_W + 1;

  logic [`DATA_W-1:0] mem [0:(1<<MEM_AW)-1];

  // write side state
  wr_state_t wr_state;
  tag_t wr_tag; // [RULE1]
  addr_t wr_addr;
  logic wr_normal;

  // read side state
  logic rd_busy;
  tag_t rd_tag;
  addr_t rd_addr;
  len_t rd_cnt;
  logic rd_normal;
  logic [`DATA_W-1:0] rd_data;

  // queue wiring
  logic bq_full;
  logic bq_empty;
  tag_t bq_head;
  logic rq_full;
  logic rq_empty;
  logic [RQ_W-1:0] rq_head;

  // handshakes
  wire aw_fire = link.aw_valid && link.aw_ready;
  wire w_fire = link.w_valid && link.w_ready;
  wire b_fire = link.b_valid && link.b_ready;
  wire ar_fire = link.ar_valid && link.ar_ready;
  wire r_fire = link.r_valid && link.r_ready;
  wire w_end = w_fire && link.w_last;

  // port bits prefix the source id so ordering stays per source
  wire [`SLV_ID_W-1:0] aw_tag = {PORT_NUM, link.aw_id}; // [RULE9] [RULE6]
  wire [`SLV_ID_W-1:0] ar_tag = {PORT_NUM, link.ar_id}; // [RULE9]

  // cache kind decode, nonzero upper bits marks normal memory
  wire aw_normal =
    link.aw_cache[`CACHE_KIND_HI:`CACHE_KIND_LO] !=
    `CACHE_KIND_DEVICE; // [RULE13]
  wire ar_normal =
    link.ar_cache[`CACHE_KIND_HI:`CACHE_KIND_LO] !=
    `CACHE_KIND_DEVICE; // [RULE13]

  // unpack read queue head
  wire [`SLV_ID_W-1:0] rq_tag = rq_head[RQ_W-1 -: `SLV_ID_W];
  wire [`ADDR_W-1:0] rq_addr = rq_head[`ADDR_W+`LEN_W : `LEN_W+1];
  wire [`LEN_W-1:0] rq_len = rq_head[`LEN_W:1];
  wire rq_normal = rq_head[0];
  wire rd_load = !rq_empty && (!rd_busy || (r_fire && link.r_last));
  wire rd_last = rd_busy && (rd_cnt == '0);

  // word addresses into the local store
  wire [MEM_AW-1:0] wr_word = wr_addr[MEM_AW-1:0]; // [RULE14]
  wire [MEM_AW-1:0] rq_word = rq_addr[MEM_AW-1:0];
  wire [MEM_AW-1:0] rd_next_word = rd_addr[MEM_AW-1:0] + MEM_AW'(1);

  // one write burst at a time, taken only if its response can queue
  assign link.aw_ready = (wr_state == W_IDLE) && !bq_full; // [RULE4] [RULE7]
  // data belongs to the single open write address, in order
  assign link.w_ready = (wr_state == W_DATA); // [RULE4] [RULE3]
  assign link.b_valid = !bq_empty;
  // port bits removed on the way back
  assign link.b_id = bq_head[`MST_ID_W-1:0]; // [RULE17]
  assign link.ar_ready = !rq_full;
  assign link.r_valid = rd_busy;
  assign link.r_id = rd_tag[`MST_ID_W-1:0]; // [RULE17]
  assign link.r_data = rd_data;
  assign link.r_last = rd_last;

  // write responses leave strictly in completion order
  order_queue #(
    .WIDTH(`SLV_ID_W),
    .DEPTH(DEPTH)
  ) u_bq (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .push_i(w_end),
    .data_i(wr_tag),
    .pop_i(b_fire),
    .head_o(bq_head),
    .full_o(bq_full),
    .empty_o(bq_empty)
  ); // [RULE16] [RULE22]

  // reads are served strictly in arrival order
  order_queue #(
    .WIDTH(RQ_W),
    .DEPTH(DEPTH)
  ) u_rq (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .push_i(ar_fire),
    .data_i({ar_tag, link.ar_addr, link.ar_len, ar_normal}),
    .pop_i(rd_load),
    .head_o(rq_head),
    .full_o(rq_full),
    .empty_o(rq_empty)
  ); // [RULE15] [RULE16] [RULE21] [RULE22]

  // write path: store each beat before any response can leave
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_state <= W_IDLE;
      wr_tag <= '0;
      wr_addr <= '0;
      wr_normal <= 1'b0;
    end else if (ce_i) begin
      unique case (wr_state)
        W_IDLE: begin
          if (aw_fire) begin
            wr_tag <= aw_tag; // [RULE6]
            wr_addr <= link.aw_addr;
            wr_normal <= aw_normal;
            wr_state <= W_DATA;
          end
        end
        W_DATA: begin
          if (w_fire) begin
            wr_addr <= wr_addr + `ADDR_W'(1);
            if (link.w_last) begin
              wr_state <= W_IDLE;
            end
          end
        end
      endcase
    end
  end

  // memory commit happens at the beat, so later accesses see it
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && w_fire && !rst_i) begin
      mem[wr_word] <= link.w_data; // [RULE19] [RULE20] [RULE18] [RULE8]
    end
  end

  // read path: head of queue streams out one beat per handshake
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_busy <= 1'b0;
      rd_tag <= '0;
      rd_addr <= '0;
      rd_cnt <= '0;
      rd_normal <= 1'b0;
      rd_data <= '0;
    end else if (ce_i) begin
      if (rd_load) begin
        rd_busy <= 1'b1;
        rd_tag <= rq_tag;
        rd_addr <= rq_addr;
        rd_cnt <= rq_len;
        rd_normal <= rq_normal;
        rd_data <= mem[rq_word]; // [RULE19]
      end else if (r_fire) begin
        if (link.r_last) begin
          rd_busy <= 1'b0;
        end else begin
          rd_addr <= rd_addr + `ADDR_W'(1);
          rd_cnt <= rd_cnt - `LEN_W'(1);
          rd_data <= mem[rd_next_word];
        end
      end
    end
  end

  // completion reports, one-cycle pulses
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_done_o <= 1'b0;
      wr_tag_o <= '0;
      wr_normal_o <= 1'b0;
      rd_done_o <= 1'b0;
      rd_tag_o <= '0;
      rd_normal_o <= 1'b0;
    end else if (ce_i) begin
      wr_done_o <= w_end;
      rd_done_o <= r_fire && rd_last;
      if (w_end) begin
        wr_tag_o <= wr_tag;
        wr_normal_o <= wr_normal;
      end
      if (r_fire && rd_last) begin
        rd_tag_o <= rd_tag;
        rd_normal_o <= rd_normal;
      end
    end
  end
endmodule : order_target

// [rtl/order_source.sv]
`timescale 1ns/1ns
`include "order_params.svh"
module order_source
  import order_pkg::*;
#(
  parameter bit FIXED_ID_EN = 1'b0,
  parameter int WR_INTERLEAVE_DEPTH = `WR_INTERLEAVE_DEPTH
) (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // link
  order_link.src link,
  // command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic [`MST_ID_W-1:0] cmd_id_i,
  input wire logic [`ADDR_W-1:0] cmd_addr_i,
  input wire logic [`LEN_W-1:0] cmd_len_i,
  input wire logic [`CACHE_W-1:0] cmd_cache_i,
  // write data
  input wire logic wdata_valid_i,
  output logic wdata_ready_o,
  input wire logic [`DATA_W-1:0] wdata_i,
  // responses
  output logic rsp_valid_o,
  output logic rsp_write_o,
  output logic [`MST_ID_W-1:0] rsp_id_o,
  output logic [`DATA_W-1:0] rsp_data_o,
  output logic rsp_last_o
);
  src_state_t state;
  logic [`MST_ID_W-1:0] id_q;
  addr_t addr_q;
  len_t len_q;
  logic [`CACHE_W-1:0] cache_q;
  len_t beats;
  logic w_valid_q;
  logic [`DATA_W-1:0] w_data_q;
  logic w_last_q;
  logic [`OUT_W-1:0] wr_out;
  logic [`OUT_W-1:0] rd_out;

  wire [`MST_ID_W-1:0] id_out = FIXED_ID_EN ? `FIXED_ID : id_q; // [RULE2]
  wire b_fire = link.b_valid && link.b_ready;
  wire r_fire = link.r_valid && link.r_ready;
  wire r_done = r_fire && link.r_last;
  // wait for the other direction to drain before switching
  wire dir_clear = cmd_write_i ? (rd_out == '0) : (wr_out == '0); // [RULE11]
  wire wr_room = wr_out != '1;
  wire rd_room = rd_out != '1;
  wire cmd_fire = cmd_valid_i && cmd_ready_o;
  wire w_slot = !w_valid_q || link.w_ready;
  wire take = wdata_valid_i && wdata_ready_o;
  wire aw_fire = link.aw_valid && link.aw_ready;
  wire ar_fire = link.ar_valid && link.ar_ready;

  assign cmd_ready_o = (state == M_IDLE) && dir_clear &&
                       (cmd_write_i ? wr_room : rd_room); // [RULE12]
  assign link.aw_valid = (state == M_AW);
  assign link.aw_id = id_out;
  assign link.aw_addr = addr_q;
  assign link.aw_len = len_q;
  assign link.aw_cache = cache_q;
  assign link.ar_valid = (state == M_AR);
  assign link.ar_id = id_out;
  assign link.ar_addr = addr_q;
  assign link.ar_len = len_q;
  assign link.ar_cache = cache_q;
  // one burst's beats only, never mixed (interleave depth one)
  assign wdata_ready_o = (state == M_W) && w_slot &&
                         (WR_INTERLEAVE_DEPTH == 1); // [RULE3] [RULE5]
  assign link.w_valid = w_valid_q;
  assign link.w_data = w_data_q;
  assign link.w_last = w_last_q;
  // read data wins, write response waits while r_valid is high
  assign link.b_ready = !link.r_valid;
  assign link.r_ready = 1'b1;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= M_IDLE;
      id_q <= '0;
      addr_q <= '0;
      len_q <= '0;
      cache_q <= '0;
      beats <= '0;
      w_valid_q <= 1'b0;
      w_data_q <= '0;
      w_last_q <= 1'b0;
    end else if (ce_i) begin
      unique case (state)
        M_IDLE: begin
          if (cmd_fire) begin
            id_q <= cmd_id_i;
            addr_q <= cmd_addr_i;
            len_q <= cmd_len_i;
            cache_q <= cmd_cache_i;
            state <= cmd_write_i ? M_AW : M_AR;
          end
        end
        M_AW: begin
          if (aw_fire) begin
            beats <= len_q;
            state <= M_W; // [RULE4]
          end
        end
        M_AR: begin
          if (ar_fire) begin
            state <= M_IDLE;
          end
        end
        M_W: begin
          if (take) begin
            beats <= beats - `LEN_W'(1);
            if (beats == '0) begin
              state <= M_IDLE;
            end
          end
        end
      endcase
      if (take) begin
        w_valid_q <= 1'b1;
        w_data_q <= wdata_i;
        w_last_q <= (beats == '0);
      end else if (link.w_ready) begin
        w_valid_q <= 1'b0;
      end
    end
  end

  // outstanding counts per direction
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_out <= '0;
      rd_out <= '0;
    end else if (ce_i) begin
      wr_out <= wr_out + `OUT_W'(aw_fire) - `OUT_W'(b_fire);
      rd_out <= rd_out + `OUT_W'(ar_fire) - `OUT_W'(r_done);
    end
  end

  // responses to the user, in the order the link returns them
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_write_o <= 1'b0;
      rsp_id_o <= '0;
      rsp_data_o <= '0;
      rsp_last_o <= 1'b0;
    end else if (ce_i) begin
      rsp_valid_o <= b_fire || r_fire; // [RULE10]
      rsp_write_o <= b_fire;
      if (r_fire) begin
        rsp_id_o <= link.r_id;
        rsp_data_o <= link.r_data;
        rsp_last_o <= link.r_last;
      end else if (b_fire) begin
        rsp_id_o <= link.b_id;
        rsp_data_o <= '0;
        rsp_last_o <= 1'b1;
      end
    end
  end
endmodule : order_source

// [tb/order_props.sv]
`timescale 1ns/1ns
`include "order_params.svh"
module order_props (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // link signals
  input wire logic aw_valid,
  input wire logic aw_ready,
  input wire logic [`MST_ID_W-1:0] aw_id,
  input wire logic [`ADDR_W-1:0] aw_addr,
  input wire logic [`LEN_W-1:0] aw_len,
  input wire logic w_valid,
  input wire logic w_ready,
  input wire logic w_last,
  input wire logic b_valid,
  input wire logic b_ready,
  input wire logic [`MST_ID_W-1:0] b_id,
  input wire logic ar_valid,
  input wire logic ar_ready,
  input wire logic [`MST_ID_W-1:0] ar_id,
  input wire logic [`ADDR_W-1:0] ar_addr,
  input wire logic r_valid,
  input wire logic r_ready,
  input wire logic [`MST_ID_W-1:0] r_id,
  input wire logic r_last
);
  logic [`MST_ID_W-1:0] aw_q [16];
  logic [`MST_ID_W-1:0] ar_q [16];
  logic [3:0] aw_wp, aw_rp, ar_wp, ar_rp;
  logic [`LEN_W-1:0] w_cnt, w_len;
  logic w_open;
  wire aw_hs = aw_valid && aw_ready;
  wire ar_hs = ar_valid && ar_ready;
  wire w_hs = w_valid && w_ready;
  wire b_hs = b_valid && b_ready;
  wire r_end = r_valid && r_ready && r_last;

  // issue order of ids per direction
  always_ff @(posedge ref_clk_i) begin
    if (aw_hs) aw_q[aw_wp] <= aw_id;
    if (ar_hs) ar_q[ar_wp] <= ar_id;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      aw_wp <= 4'h0;
      aw_rp <= 4'h0;
      ar_wp <= 4'h0;
      ar_rp <= 4'h0;
      w_open <= 1'b0;
      w_cnt <= 8'h00;
      w_len <= 8'h00;
    end else begin
      aw_wp <= aw_wp + 4'(aw_hs);
      aw_rp <= aw_rp + 4'(b_hs);
      ar_wp <= ar_wp + 4'(ar_hs);
      ar_rp <= ar_rp + 4'(r_end);
      w_open <= aw_hs || (w_open && !(w_hs && w_last));
      w_cnt <= aw_hs ? 8'h00 : w_cnt + 8'(w_hs);
      if (aw_hs) w_len <= aw_len;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_aw_held: assert property (aw_valid && !aw_ready |=>
    aw_valid && $stable(aw_id) && $stable(aw_addr))
    else $error("write address dropped or changed while waiting");
  a_ar_held: assert property (ar_valid && !ar_ready |=>
    ar_valid && $stable(ar_id) && $stable(ar_addr))
    else $error("read address dropped or changed while waiting");
  a_b_held: assert property (b_valid && !b_ready |=>
    b_valid && $stable(b_id))
    else $error("write response dropped or changed while waiting");
  a_aw_blocked: assert property (w_open |-> !aw_ready)
    else $error("second write address taken during a burst");
  a_w_inside: assert property (!w_open |-> !w_valid)
    else $error("write data outside its address burst");
  a_w_last_pos: assert property (w_valid |->
    w_last == (w_cnt == w_len))
    else $error("last write beat flag on wrong beat");
  a_b_in_order: assert property (b_valid |-> b_id == aw_q[aw_rp])
    else $error("write response id out of issue order");
  a_r_in_order: assert property (r_valid |-> r_id == ar_q[ar_rp])
    else $error("read data id out of issue order");
  a_w_ready_next: assert property (aw_hs |=> w_ready ##0 w_open)
    else $error("write data not accepted after address");

  c_w_burst: cover property (w_hs && w_last && w_len != 8'h00);
  c_r_burst: cover property (r_end);
  c_b_stall: cover property (b_valid && !b_ready);
endmodule : order_props

// [tb/tb_top.sv]
`timescale 1ns/1ns
`include "order_params.svh"
module tb_top;
  logic ref_clk_i, rst_i, cmd_valid_i, cmd_ready_o, cmd_write_i;
  logic [3:0] cmd_id_i, cmd_cache_i, rsp_id_o;
  logic [15:0] cmd_addr_i;
  logic [7:0] cmd_len_i, wr_tag_o, rd_tag_o, last_wtag, last_rtag;
  logic wdata_valid_i, wdata_ready_o, rsp_valid_o, rsp_write_o, rsp_last_o;
  logic [31:0] wdata_i, rsp_data_o;
  logic wr_done_o, wr_normal_o, rd_done_o, rd_normal_o, last_wnorm, last_rnorm;
  logic [37:0] rsp_q [$];
  int mismatches, samples_checked;

  order_link order_link_i ();
  order_source order_source_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .link(order_link_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i),
    .cmd_id_i(cmd_id_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i),
    .cmd_cache_i(cmd_cache_i), .wdata_valid_i(wdata_valid_i),
    .wdata_ready_o(wdata_ready_o), .wdata_i(wdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_write_o(rsp_write_o),
    .rsp_id_o(rsp_id_o), .rsp_data_o(rsp_data_o), .rsp_last_o(rsp_last_o));
  order_target order_target_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .link(order_link_i), .wr_done_o(wr_done_o),
    .wr_tag_o(wr_tag_o), .wr_normal_o(wr_normal_o), .rd_done_o(rd_done_o),
    .rd_tag_o(rd_tag_o), .rd_normal_o(rd_normal_o));
  order_props order_props_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .aw_valid(order_link_i.aw_valid), .aw_ready(order_link_i.aw_ready),
    .aw_id(order_link_i.aw_id), .aw_addr(order_link_i.aw_addr),
    .aw_len(order_link_i.aw_len), .w_valid(order_link_i.w_valid),
    .w_ready(order_link_i.w_ready), .w_last(order_link_i.w_last),
    .b_valid(order_link_i.b_valid), .b_ready(order_link_i.b_ready),
    .b_id(order_link_i.b_id), .ar_valid(order_link_i.ar_valid),
    .ar_ready(order_link_i.ar_ready), .ar_id(order_link_i.ar_id),
    .ar_addr(order_link_i.ar_addr), .r_valid(order_link_i.r_valid),
    .r_ready(order_link_i.r_ready), .r_id(order_link_i.r_id),
    .r_last(order_link_i.r_last));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // capture pulses where they are settled
  always @(negedge ref_clk_i) begin
    if (rsp_valid_o === 1'b1)
      rsp_q.push_back({rsp_write_o, rsp_last_o, rsp_id_o, rsp_data_o});
    if (wr_done_o === 1'b1) begin
      last_wtag = wr_tag_o;
      last_wnorm = wr_normal_o;
    end
    if (rd_done_o === 1'b1) begin
      last_rtag = rd_tag_o;
      last_rnorm = rd_normal_o;
    end
  end

  task chk(input string what, input logic [37:0] exp, input logic [37:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task wait_ready(input bit data);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    while ((data ? wdata_ready_o : cmd_ready_o) !== 1'b1) begin
      n++;
      if (n > 200) begin
        chk("handshake wait", 38'h1, 38'h0);
        conclude();
      end
      @(negedge ref_clk_i);
    end
    @(posedge ref_clk_i);
    #1;
  endtask : wait_ready

  task issue(input logic wr, input logic [3:0] id, input logic [15:0] addr,
             input logic [7:0] len, input logic [3:0] cache,
             input logic [31:0] base);
    cmd_valid_i = 1'b1;
    cmd_write_i = wr;
    cmd_id_i = id;
    cmd_addr_i = addr;
    cmd_len_i = len;
    cmd_cache_i = cache;
    wait_ready(1'b0);
    cmd_valid_i = 1'b0;
    for (int i = 0; wr && i <= int'(len); i++) begin
      wdata_valid_i = 1'b1;
      wdata_i = base + 32'(i);
      wait_ready(1'b1);
    end
    wdata_valid_i = 1'b0;
    // after a read, let an edge pass so a following command never re-raises valid at once
    if (!wr) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask : issue

  task expect_rsp(input logic [37:0] exp);
    int n;
    n = 0;
    while (rsp_q.size() == 0) begin
      n++;
      if (n > 200) begin
        chk("response wait", exp, 38'h0);
        conclude();
      end
      @(posedge ref_clk_i);
      #1;
    end
    chk("response", exp, rsp_q.pop_front());
  endtask : expect_rsp

  task s_burst;
    issue(1'b1, 4'h3, 16'h0010, 8'h03, 4'h0, 32'ha000_0000);
    expect_rsp({2'b11, 4'h3, 32'h0});
    chk("write tag", 38'({`PORT_NUM, 4'h3}), 38'(last_wtag));
    issue(1'b0, 4'h3, 16'h0010, 8'h03, 4'h0, 32'h0);
    for (int i = 0; i < 4; i++)
      expect_rsp({1'b0, i == 3, 4'h3, 32'ha000_0000 + 32'(i)});
    $display("test burst done");
  endtask : s_burst

  task s_overlap;
    issue(1'b1, 4'h5, 16'h0020, 8'h00, 4'h0, 32'h11);
    issue(1'b1, 4'h5, 16'h0020, 8'h00, 4'h2, 32'h22);
    expect_rsp({2'b11, 4'h5, 32'h0});
    expect_rsp({2'b11, 4'h5, 32'h0});
    chk("normal flag", 38'h1, 38'(last_wnorm));
    issue(1'b0, 4'h5, 16'h0020, 8'h00, 4'h0, 32'h0);
    expect_rsp({2'b01, 4'h5, 32'h22});
    $display("test overlap done");
  endtask : s_overlap

  task s_read_order;
    issue(1'b0, 4'h1, 16'h0010, 8'h01, 4'h0, 32'h0);
    issue(1'b0, 4'h1, 16'h0013, 8'h00, 4'h0, 32'h0);
    issue(1'b0, 4'h2, 16'h0011, 8'h02, 4'h8, 32'h0);
    expect_rsp({2'b00, 4'h1, 32'ha000_0000});
    expect_rsp({2'b01, 4'h1, 32'ha000_0001});
    expect_rsp({2'b01, 4'h1, 32'ha000_0003});
    for (int i = 1; i < 4; i++)
      expect_rsp({1'b0, i == 3, 4'h2, 32'ha000_0000 + 32'(i)});
    chk("read tag", 38'({`PORT_NUM, 4'h2}), 38'(last_rtag));
    chk("read normal", 38'h1, 38'(last_rnorm));
    $display("test read order done");
  endtask : s_read_order

  task s_cache_codes;
    for (int c = 0; c < 16; c++) begin
      issue(1'b1, 4'(c), 16'h0040 + 16'(c), 8'h00, 4'(c), 32'(c));
      expect_rsp({2'b11, 4'(c), 32'h0});
      chk("normal flag", 38'(c > 1), 38'(last_wnorm));
      chk("write tag", 38'({`PORT_NUM, 4'(c)}), 38'(last_wtag));
    end
    $display("test cache codes done");
  endtask : s_cache_codes

  initial begin
    mismatches = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_write_i = 1'b0;
    cmd_id_i = 4'h0;
    cmd_addr_i = 16'h0000;
    cmd_len_i = 8'h00;
    cmd_cache_i = 4'h0;
    wdata_valid_i = 1'b0;
    wdata_i = 32'h0;
    repeat (6) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    s_burst();
    s_overlap();
    s_read_order();
    s_cache_codes();
    conclude();
  end
endmodule : tb_top
